/* File: pkg/purcs_defines.svh */
// constants for the power-up reset and clock start sequencer
`ifndef PURCS_DEFINES_SVH
`define PURCS_DEFINES_SVH
`define PURCS_OSC_MHZ          8
`define PURCS_DEF_CLK_MHZ      1
`define PURCS_DIV_WIDTH        3
`define PURCS_DIV_HALF         3'h3
`define PURCS_DIV_LAST         3'h7
`define PURCS_STABLE_CYCLES    16'h0040
`define PURCS_RESET_VECTOR     32'h00000000
`define PURCS_GCLK_COUNT       9
`define PURCS_GCLK_EN_RESET    9'h003
`define PURCS_SYS_CLK_COUNT    8
`define PURCS_SYS_CLK_EN_RESET 8'h0F
`define PURCS_PIN_COUNT        19
`endif

/* File: pkg/purcs_pkg.sv */
// types shared by the power-up reset and clock start sequencer
package purcs_pkg;
    typedef enum logic [2:0] {
        PURCS_ST_POR     = 3'h0,
        PURCS_ST_SETTLE  = 3'h1,
        PURCS_ST_CLKSTRT = 3'h2,
        PURCS_ST_RUN     = 3'h3
    } purcs_state_t;

    typedef struct packed {
        logic analogSupplyOk;
        logic coreSupplyOk;
        logic standbyReq;
    } purcs_supply_t;

    typedef struct packed {
        purcs_state_t state;
        logic [15:0]  settleCnt;
        logic [2:0]   divCnt;
        logic         defClk;
        logic         cpuReset;
        logic         coreBodActive;
        logic         lowPowerRegulatorMode;
    } purcs_regs_t;
endpackage : purcs_pkg

/* File: design/power_up_reset_clock_start.sv */
// power-up reset sequencing, default clock start and supply monitoring
`include "purcs_defines.svh"

// Summary of operation
// - hold all logic in reset until the analog supply has stayed good for the settle window
// - after release the device runs from a default 1 MHz clock
// - default clock is the 8 MHz oscillator divided by eight, feeding generator 0
// - generator 0 clocks the power manager unit after power-up
// - a default subset of system clocks is enabled at start-up
// - default system clocks are undivided, taking 1 MHz from generator 0
// - all generic clocks but generator 0 and watchdog clock are off at power-up
// - every I/O pin stays high-impedance after power-up
// - processor fetches PC and SP from reset address zero
// - analog-supply power-on monitor is always on, no disable
// - analog supply below threshold applies a full-chip reset
// - core-supply brown-out monitor starts only after start-up completes
// - regulator has normal mode and low-power mode for standby
module power_up_reset_clock_start #(
    parameter int STABLE_CYCLES = `PURCS_STABLE_CYCLES
) (
    input  wire logic                               clk,
    input  wire logic                               arst_n,
    input  wire purcs_pkg::purcs_supply_t           supply,
    output logic                                    coreReset_n,
    output logic                                    cpuResetRelease,
    output logic [31:0]                             resetVector,
    output logic                                    generatorZeroClk,
    output logic                                    powerManagerClk,
    output logic [`PURCS_GCLK_COUNT-1:0]            genericClockEnable,
    output logic [`PURCS_SYS_CLK_COUNT-1:0]         systemClockEnable,
    output logic [`PURCS_SYS_CLK_COUNT-1:0]         systemClockDivided,
    output logic [`PURCS_PIN_COUNT-1:0]             pinOutputEnable,
    output logic                                    coreBodActive,
    output logic                                    coreBrownout,
    output logic                                    lowPowerRegulatorMode
);
    purcs_pkg::purcs_regs_t regsQ;
    purcs_pkg::purcs_regs_t regsD;
    // monitor has no enable: the analog supply flag is read unconditionally
    logic analogLow;
    assign analogLow = !supply.analogSupplyOk;

    always_comb begin
        regsD = regsQ;
        case (regsQ.state)
            purcs_pkg::PURCS_ST_POR: begin
                regsD.settleCnt = '0;
                regsD.cpuReset  = 1'b1;
                if (!analogLow) begin
                    regsD.state = purcs_pkg::PURCS_ST_SETTLE;
                end
            end
            purcs_pkg::PURCS_ST_SETTLE: begin
                // the analog supply must stay good for the whole window before release
                if (regsQ.settleCnt == 16'(STABLE_CYCLES - 1)) begin
                    regsD.state = purcs_pkg::PURCS_ST_CLKSTRT;
                end else begin
                    regsD.settleCnt = regsQ.settleCnt + 16'h0001;
                end
            end
            purcs_pkg::PURCS_ST_CLKSTRT: begin
                regsD.cpuReset      = 1'b0;
                regsD.divCnt        = '0;
                regsD.defClk        = 1'b0;
                regsD.state         = purcs_pkg::PURCS_ST_RUN;
            end
            purcs_pkg::PURCS_ST_RUN: begin
                regsD.coreBodActive = 1'b1;
                regsD.divCnt = regsQ.divCnt + 3'h1;
                if (regsQ.divCnt == `PURCS_DIV_HALF) begin
                    regsD.defClk = 1'b1;
                end else if (regsQ.divCnt == `PURCS_DIV_LAST) begin
                    regsD.defClk = 1'b0;
                end
                regsD.lowPowerRegulatorMode = supply.standbyReq;
            end
            default: begin
                regsD.state = purcs_pkg::PURCS_ST_POR;
            end
        endcase
        if (analogLow) begin
            // full-chip reset from the monitor, in any state
            regsD.state                 = purcs_pkg::PURCS_ST_POR;
            regsD.cpuReset              = 1'b1;
            regsD.divCnt                = '0;
            regsD.defClk                = 1'b0;
            regsD.coreBodActive         = 1'b0;
            regsD.lowPowerRegulatorMode = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regsQ.state                 <= purcs_pkg::PURCS_ST_POR;
            regsQ.settleCnt             <= '0;
            regsQ.divCnt                <= '0;
            regsQ.defClk                <= 1'b0;
            regsQ.cpuReset              <= 1'b1;
            regsQ.coreBodActive         <= 1'b0;
            regsQ.lowPowerRegulatorMode <= 1'b0;
        end else begin
            regsQ <= regsD;
        end
    end

    assign coreReset_n           = !regsQ.cpuReset;
    assign cpuResetRelease       = !regsQ.cpuReset;
    assign resetVector           = `PURCS_RESET_VECTOR;
    assign generatorZeroClk      = regsQ.defClk;
    assign powerManagerClk       = regsQ.defClk;
    // clock gates fixed at defaults; software reconfiguration lives elsewhere
    assign genericClockEnable    = `PURCS_GCLK_EN_RESET;
    assign systemClockEnable     = `PURCS_SYS_CLK_EN_RESET;
    assign systemClockDivided    = '0;
    assign pinOutputEnable       = '0;
    assign coreBodActive         = regsQ.coreBodActive;
    assign coreBrownout          = regsQ.coreBodActive && !supply.coreSupplyOk;
    assign lowPowerRegulatorMode = regsQ.lowPowerRegulatorMode;

    a_reset_held_low: assert property (@(posedge clk) disable iff (!arst_n)
        !supply.analogSupplyOk |=> !coreReset_n)
        else $error("reset not applied on low analog supply");

    a_release_after_settle: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(coreReset_n) |-> regsQ.settleCnt == 16'(STABLE_CYCLES - 1))
        else $error("reset released before settle window");

    a_clock_period_eight: assert property (@(posedge clk) disable iff (!arst_n)
        ($rose(generatorZeroClk) && supply.analogSupplyOk)
        ##1 supply.analogSupplyOk [*7] |=> $rose(generatorZeroClk))
        else $error("default clock period not eight cycles");

    a_clock_after_release: assert property (@(posedge clk) disable iff (!arst_n)
        !coreReset_n |-> !generatorZeroClk)
        else $error("clock pulse while in reset");

    a_core_bod_start: assert property (@(posedge clk) disable iff (!arst_n)
        coreBodActive |-> coreReset_n)
        else $error("core monitor active before start-up");

    a_pins_tristate: assert property (@(posedge clk) disable iff (!arst_n)
        pinOutputEnable == '0)
        else $error("pin driven after power-up");

    a_manager_clock_gen0: assert property (@(posedge clk) disable iff (!arst_n)
        powerManagerClk == generatorZeroClk)
        else $error("power manager clock differs from generator 0");

    a_gclk_defaults: assert property (@(posedge clk) disable iff (!arst_n)
        genericClockEnable == `PURCS_GCLK_EN_RESET
        && systemClockDivided == '0)
        else $error("generic clock defaults wrong");

    a_regulator_standby: assert property (@(posedge clk) disable iff (!arst_n)
        lowPowerRegulatorMode |-> $past(supply.standbyReq))
        else $error("low-power regulator mode without standby");

    a_low_restarts_seq: assert property (@(posedge clk) disable iff (!arst_n)
        !supply.analogSupplyOk |=> regsQ.state == purcs_pkg::PURCS_ST_POR)
        else $error("sequence not restarted on low analog supply");

    // a counter that skips would shorten the settle window
    a_settle_count_step: assert property (@(posedge clk) disable iff (!arst_n)
        (regsQ.state == purcs_pkg::PURCS_ST_SETTLE && supply.analogSupplyOk
        && regsQ.settleCnt != 16'(STABLE_CYCLES - 1))
        |=> regsQ.settleCnt == $past(regsQ.settleCnt) + 16'h0001)
        else $error("settle counter skipped a cycle");

    a_release_needs_ok: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(coreReset_n) |-> $past(supply.analogSupplyOk))
        else $error("reset released on a low analog supply");

    a_divider_start_zero: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(coreReset_n) |-> regsQ.divCnt == '0 && !generatorZeroClk)
        else $error("divider not cleared at release");

    // first default clock edge lands four cycles into run
    a_clock_first_rise: assert property (@(posedge clk) disable iff (!arst_n)
        ($rose(coreReset_n) && supply.analogSupplyOk)
        ##1 supply.analogSupplyOk [*3] |=> $rose(generatorZeroClk))
        else $error("first default clock edge misplaced");

    a_clock_high_four: assert property (@(posedge clk) disable iff (!arst_n)
        ($rose(generatorZeroClk) && supply.analogSupplyOk)
        ##1 supply.analogSupplyOk [*3] |=> $fell(generatorZeroClk))
        else $error("default clock high phase not four cycles");

    a_bod_after_release: assert property (@(posedge clk) disable iff (!arst_n)
        ($rose(coreReset_n) && supply.analogSupplyOk) |=> coreBodActive)
        else $error("core monitor not started after start-up");

    a_bod_low_clears: assert property (@(posedge clk) disable iff (!arst_n)
        !supply.analogSupplyOk |=> !coreBodActive && !coreBrownout)
        else $error("core monitor left running through chip reset");

    a_brownout_needs_bod: assert property (@(posedge clk) disable iff (!arst_n)
        !coreBodActive |-> !coreBrownout)
        else $error("core brownout reported before start-up");

    a_bod_reports_sag: assert property (@(posedge clk) disable iff (!arst_n)
        coreBodActive && !supply.coreSupplyOk |-> coreBrownout)
        else $error("core supply sag not reported");

    a_regulator_low_clear: assert property (@(posedge clk) disable iff (!arst_n)
        !supply.analogSupplyOk |=> !lowPowerRegulatorMode)
        else $error("regulator mode kept through chip reset");

    a_regulator_follows: assert property (@(posedge clk) disable iff (!arst_n)
        (regsQ.state == purcs_pkg::PURCS_ST_RUN && supply.analogSupplyOk)
        |=> lowPowerRegulatorMode == $past(supply.standbyReq))
        else $error("regulator mode does not follow standby");

    a_sysclk_defaults: assert property (@(posedge clk) disable iff (!arst_n)
        systemClockEnable == `PURCS_SYS_CLK_EN_RESET)
        else $error("system clock defaults wrong");

    a_fetch_vector_zero: assert property (@(posedge clk) disable iff (!arst_n)
        cpuResetRelease |-> coreReset_n && resetVector == `PURCS_RESET_VECTOR)
        else $error("fetch released with wrong vector or in reset");

    a_state_legal: assert property (@(posedge clk) disable iff (!arst_n)
        regsQ.state inside {purcs_pkg::PURCS_ST_POR, purcs_pkg::PURCS_ST_SETTLE,
        purcs_pkg::PURCS_ST_CLKSTRT, purcs_pkg::PURCS_ST_RUN})
        else $error("sequencer state out of range");
endmodule : power_up_reset_clock_start

/* File: tb/purcs_rail_model.sv */
// supply rail and standby request model facing the sequencer
module purcs_rail_model (
    input  wire logic               analogDrop,
    input  wire logic               coreDrop,
    input  wire logic               standby,
    output purcs_pkg::purcs_supply_t supply
);
    timeunit 1ns;
    timeprecision 1ps;
    // no filtering: a commanded sag shows at once, as a real rail may
    assign supply = '{analogSupplyOk: !analogDrop, coreSupplyOk: !coreDrop, standbyReq: standby};
endmodule : purcs_rail_model

/* File: tb/power_up_reset_clock_start_tb_top.sv */
// self-checking bench for the power-up reset and clock start sequencer
`include "purcs_defines.svh"
module power_up_reset_clock_start_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int S = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic analogDrop = 1'b0;
    logic coreDrop = 1'b0;
    logic standby = 1'b0;
    logic lastStandby;
    purcs_pkg::purcs_supply_t supply;
    logic coreReset_n, cpuResetRelease, generatorZeroClk, powerManagerClk;
    logic coreBodActive, coreBrownout, lowPowerRegulatorMode;
    logic [31:0] resetVector;
    logic [`PURCS_GCLK_COUNT-1:0] genericClockEnable;
    logic [`PURCS_SYS_CLK_COUNT-1:0] systemClockEnable, systemClockDivided;
    logic [`PURCS_PIN_COUNT-1:0] pinOutputEnable;
    int bad_count = 0;
    int tests_run = 0;
    int okCnt;
    integer seed = 32'h17d8d998;

    purcs_rail_model purcs_rail_model_inst (.analogDrop(analogDrop), .coreDrop(coreDrop),
        .standby(standby), .supply(supply));
    power_up_reset_clock_start #(.STABLE_CYCLES(S)) power_up_reset_clock_start_inst (
        .clk(clk), .arst_n(arst_n), .supply(supply), .coreReset_n(coreReset_n),
        .cpuResetRelease(cpuResetRelease), .resetVector(resetVector),
        .generatorZeroClk(generatorZeroClk), .powerManagerClk(powerManagerClk),
        .genericClockEnable(genericClockEnable), .systemClockEnable(systemClockEnable),
        .systemClockDivided(systemClockDivided), .pinOutputEnable(pinOutputEnable),
        .coreBodActive(coreBodActive), .coreBrownout(coreBrownout),
        .lowPowerRegulatorMode(lowPowerRegulatorMode));

    initial begin
        forever #2 clk = ~clk;
    end

    // count of consecutive edges with the analog rail good
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            okCnt <= 0;
            lastStandby <= 1'b0;
        end else begin
            okCnt <= supply.analogSupplyOk ? okCnt + 1 : 0;
            lastStandby <= supply.standbyReq;
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic compare_all();
        logic run;
        logic bod;
        logic gz;
        run = okCnt >= S + 2;
        bod = okCnt >= S + 3;
        gz = run && ((okCnt - S - 2) % 8 >= 4);
        check(coreReset_n, run, "chip reset");
        check(cpuResetRelease, run, "fetch release");
        check(resetVector, 32'h00000000, "vector");
        check(generatorZeroClk, gz, "default clock");
        check(powerManagerClk, gz, "manager clock");
        check(genericClockEnable, `PURCS_GCLK_EN_RESET, "generic enables");
        check(systemClockEnable, `PURCS_SYS_CLK_EN_RESET, "system enables");
        check(systemClockDivided, 8'h00, "system divide");
        check(pinOutputEnable, 19'h00000, "pin drive");
        check(coreBodActive, bod, "core monitor");
        check(coreBrownout, bod && coreDrop, "core brownout");
        if (okCnt >= S + 4) begin
            check(lowPowerRegulatorMode, lastStandby, "regulator mode");
        end
    endtask : compare_all

    task automatic run_cycles(input int n, input int sagPct);
        repeat (n) begin
            @(negedge clk);
            compare_all();
            analogDrop = (($random(seed) & 32'h7FFFFFFF) % 100) < sagPct;
            coreDrop = (($random(seed) & 32'h7FFFFFFF) % 4) == 0;
            standby = $random(seed) & 1;
        end
    endtask : run_cycles

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    initial begin
        run_cycles(12, 0);
        arst_n = 1'b1;
        $display("test reset hold done");
        run_cycles(80, 0);
        $display("test start-up and clocks done");
        run_cycles(300, 3);
        $display("test analog sags done");
        arst_n = 1'b0;
        run_cycles(3, 0);
        arst_n = 1'b1;
        run_cycles(60, 0);
        $display("test second reset done");
        test_done();
    end

    initial begin
        #(4 * 2000);
        $display("unexpected at %0t: watchdog expired", $time);
        bad_count++;
        test_done();
    end
endmodule : power_up_reset_clock_start_tb_top
